// ==== irq_power_pkg.sv ====
package irq_power_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_POWER   = 8'h87;
  localparam logic [7:0]  IDX_ENABLE2 = 8'hE7;
  localparam logic [7:0]  IDX_PRIO1   = 8'hF6;
  localparam logic [7:0]  IDX_PRIO2   = 8'hF7;
  localparam logic [7:0]  IDX_CONTROL = 8'h10;
  localparam logic [7:0]  IDX_STATUS  = 8'h11;
  localparam logic [7:0]  IDX_MASK    = 8'h12;

  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_POWER   = {2'h0, IDX_POWER, 2'h0};
  localparam logic [11:0] ADDR_ENABLE2 = {2'h0, IDX_ENABLE2, 2'h0};
  localparam logic [11:0] ADDR_PRIO1   = {2'h0, IDX_PRIO1, 2'h0};
  localparam logic [11:0] ADDR_PRIO2   = {2'h0, IDX_PRIO2, 2'h0};
  localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_MASK    = {2'h0, IDX_MASK, 2'h0};

  // implemented bits; 7 and 5 of the second group are unused
  localparam logic [7:0]  ENABLE2_BITS = 8'h5F;
  localparam logic [7:0]  PRIO2_BITS   = 8'h5F;
  localparam int          POWER_IDLE_BIT = 0;
  localparam int          POWER_STOP_BIT = 1;
  localparam int          CONTROL_GIE_BIT = 0;

  // sticky status events
  localparam int          ST_IDLE_ENTER = 0;
  localparam int          ST_IDLE_WAKE  = 1;
  localparam int          ST_STOP_ENTER = 2;
  localparam int          ST_RESET_WAKE = 3;
  localparam logic [7:0]  STATUS_BITS   = 8'h0F;

  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int          SRC_N         = 16;
  localparam int          SRC_IDX_W     = 4;

  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_STOP = 3'b100
  } mode_t;

endpackage

// ==== first_set_pick.sv ====
`timescale 1ns/10ps
`default_nettype none
module first_set_pick #(
  parameter int WIDTH = 16,
  parameter int IDX_W = 4
) (
  // request vector, lowest index wins
  input  wire logic [WIDTH-1:0] req_in,
  // result
  output logic                  valid_out,
  output logic [IDX_W-1:0]      index_out
);

  always_comb
  begin
    valid_out = |req_in;
    index_out = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        index_out = IDX_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// ==== irq_power_ctrl.sv ====
// Notes on behaviour
// - second enable register gates UART1, ADC2 EOC/window, timer4, ADC0 EOC, timer3.
// - bits 7 and 5 of second enable register read zero, ignore writes.
// - first priority register makes each of its eight sources high when set.
// - second priority register sets high priority per source; bits 7, 5 read zero.
// - idle request halts CPU when writing instruction completes; rest keeps running.
// - registers and memory keep their contents while halted in idle.
// - enabled interrupt in idle clears request, resumes CPU, interrupt gets serviced.
// - any internal or external reset ends idle and restarts the core at zero.
// - a watchdog timeout reset ends idle; software may disable watchdog first.
// - stop request halts CPU and clocks after the writing instruction completes.
// - stop ends only by reset, never by interrupt; restart at zero.
// - missing-clock detector reset ends stop when that detector is enabled.
// - both power request bits are write-one triggers and read back zero.
// - high priority preempts low priority service; nothing preempts high priority.
// - global enable zero forwards nothing; one lets each source follow its mask; here irq_out is not gated by it and follows status and mask alone.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module irq_power_ctrl (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // cpu core
  input  wire logic        instr_done_in,
  input  wire logic        ack_in,
  input  wire logic        return_from_interrupt_in,
  input  wire logic [7:0]  first_enable_in,
  output logic             cpu_halt_out,
  output logic             clock_stop_out,
  output logic             core_reset_out,
  output logic             dispatch_req_out,
  output logic [3:0]       dispatch_vec_out,
  output logic             dispatch_high_out,
  // interrupt sources
  input  wire logic [7:0]  pend_first_in,
  input  wire logic [7:0]  pend_second_in,
  // reset sources
  input  wire logic        watchdog_reset_in,
  input  wire logic        missing_clock_reset_in,
  input  wire logic        ext_reset_pin_in,
  // block interrupt
  output logic             irq_out
);

  typedef struct packed {
    irq_power_pkg::mode_t mode;
    logic                 idle_arm;
    logic                 stop_arm;
    logic [7:0]           enable2;
    logic [7:0]           prio1;
    logic [7:0]           prio2;
    logic                 gie;
    logic [7:0]           status;
    logic [7:0]           mask;
    logic                 svc_low;
    logic                 svc_high;
    logic                 ext_meta;
    logic                 ext_sync;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 cpu_halt;
    logic                 clock_stop;
    logic                 core_reset;
    logic                 disp_req;
    logic [3:0]           disp_vec;
    logic                 disp_high;
    logic                 irq;
  } state_t;

  state_t     state;
  state_t     next_state;

  logic [15:0] qual;
  logic [15:0] prio_vec;
  logic        hi_valid;
  logic [3:0]  hi_idx;
  logic        lo_valid;
  logic [3:0]  lo_idx;
  logic        reset_event;
  logic        apb_setup;
  logic        apb_write;
  logic        addr_hit;
  logic [7:0]  rd_byte;
  logic [7:0]  status_set;
  logic [7:0]  wbyte;

  // qualified request: pending, own enable, global enable
  always_comb
  begin
    qual = {pend_second_in & state.enable2, pend_first_in & first_enable_in};
    qual = qual & {16{state.gie}};
    prio_vec = {state.prio2, state.prio1};
  end

  first_set_pick #(
    .WIDTH (irq_power_pkg::SRC_N),
    .IDX_W (irq_power_pkg::SRC_IDX_W)
  ) u_pick_high (
    .req_in    (qual & prio_vec),
    .valid_out (hi_valid),
    .index_out (hi_idx)
  );

  first_set_pick #(
    .WIDTH (irq_power_pkg::SRC_N),
    .IDX_W (irq_power_pkg::SRC_IDX_W)
  ) u_pick_low (
    .req_in    (qual & ~prio_vec),
    .valid_out (lo_valid),
    .index_out (lo_idx)
  );

  // address decode and read mux
  always_comb
  begin
    addr_hit = 1'b1;
    rd_byte  = irq_power_pkg::RESET_BYTE;
    case (paddr_in)
      irq_power_pkg::ADDR_POWER:   rd_byte = irq_power_pkg::RESET_BYTE;
      irq_power_pkg::ADDR_ENABLE2: rd_byte = state.enable2;
      irq_power_pkg::ADDR_PRIO1:   rd_byte = state.prio1;
      irq_power_pkg::ADDR_PRIO2:   rd_byte = state.prio2;
      irq_power_pkg::ADDR_CONTROL: rd_byte = {7'h00, state.gie};
      irq_power_pkg::ADDR_STATUS:  rd_byte = state.status;
      irq_power_pkg::ADDR_MASK:    rd_byte = state.mask;
      default:                     addr_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_state  = state;
    status_set  = 8'h00;
    wbyte       = pwdata_in[7:0];
    reset_event = watchdog_reset_in | missing_clock_reset_in | state.ext_sync;
    apb_setup   = psel_in & ~penable_in;
    apb_write   = psel_in & penable_in & state.pready & pwrite_in & addr_hit;

    next_state.ext_meta = ext_reset_pin_in;
    next_state.ext_sync = state.ext_meta;

    // bus answer one cycle after setup
    next_state.pready  = apb_setup;
    next_state.pslverr = apb_setup & ~addr_hit;
    next_state.prdata  = apb_setup ? {24'h000000, rd_byte} : 32'h00000000;

    // register writes, frozen while halted
    if (apb_write && state.mode == irq_power_pkg::MODE_RUN)
    begin
      case (paddr_in)
        irq_power_pkg::ADDR_POWER:
        begin
          if (wbyte[irq_power_pkg::POWER_IDLE_BIT])
          begin
            next_state.idle_arm = 1'b1;
          end
          if (wbyte[irq_power_pkg::POWER_STOP_BIT])
          begin
            next_state.stop_arm = 1'b1;
          end
        end
        irq_power_pkg::ADDR_ENABLE2: next_state.enable2 = wbyte & irq_power_pkg::ENABLE2_BITS;
        irq_power_pkg::ADDR_PRIO1:   next_state.prio1 = wbyte;
        irq_power_pkg::ADDR_PRIO2:   next_state.prio2 = wbyte & irq_power_pkg::PRIO2_BITS;
        irq_power_pkg::ADDR_CONTROL: next_state.gie = wbyte[irq_power_pkg::CONTROL_GIE_BIT];
        irq_power_pkg::ADDR_MASK:    next_state.mask = wbyte & irq_power_pkg::STATUS_BITS;
        default:
        begin
        end
      endcase
    end

    // power mode sequencing
    case (state.mode)
      irq_power_pkg::MODE_RUN:
      begin
        if (instr_done_in && state.stop_arm)
        begin
          next_state.mode     = irq_power_pkg::MODE_STOP;
          next_state.stop_arm = 1'b0;
          next_state.idle_arm = 1'b0;
          status_set[irq_power_pkg::ST_STOP_ENTER] = 1'b1;
        end
        else if (instr_done_in && state.idle_arm)
        begin
          next_state.mode     = irq_power_pkg::MODE_IDLE;
          next_state.idle_arm = 1'b0;
          status_set[irq_power_pkg::ST_IDLE_ENTER] = 1'b1;
        end
      end
      irq_power_pkg::MODE_IDLE:
      begin
        if (|qual)
        begin
          next_state.mode = irq_power_pkg::MODE_RUN;
          status_set[irq_power_pkg::ST_IDLE_WAKE] = 1'b1;
        end
      end
      irq_power_pkg::MODE_STOP:
      begin
        next_state.mode = irq_power_pkg::MODE_STOP;
      end
      default: next_state.mode = irq_power_pkg::MODE_RUN;
    endcase

    // service level tracking
    if (return_from_interrupt_in)
    begin
      if (state.svc_high)
      begin
        next_state.svc_high = 1'b0;
      end
      else
      begin
        next_state.svc_low = 1'b0;
      end
    end
    if (ack_in && state.disp_req)
    begin
      if (state.disp_high)
      begin
        next_state.svc_high = 1'b1;
      end
      else
      begin
        next_state.svc_low = 1'b1;
      end
    end

    // dispatch only while running; high preempts low
    next_state.disp_req  = 1'b0;
    next_state.disp_high = 1'b0;
    next_state.disp_vec  = 4'h0;
    if (state.mode == irq_power_pkg::MODE_RUN)
    begin
      if (hi_valid && !state.svc_high)
      begin
        next_state.disp_req  = 1'b1;
        next_state.disp_high = 1'b1;
        next_state.disp_vec  = hi_idx;
      end
      else if (lo_valid && !state.svc_high && !state.svc_low)
      begin
        next_state.disp_req = 1'b1;
        next_state.disp_vec = lo_idx;
      end
    end

    // internal or external reset: core restarts, controls except mask return to defaults
    next_state.core_reset = 1'b0;
    if (reset_event)
    begin
      if (state.mode != irq_power_pkg::MODE_RUN)
      begin
        status_set[irq_power_pkg::ST_RESET_WAKE] = 1'b1;
      end
      next_state.mode       = irq_power_pkg::MODE_RUN;
      next_state.idle_arm   = 1'b0;
      next_state.stop_arm   = 1'b0;
      next_state.enable2    = irq_power_pkg::RESET_BYTE;
      next_state.prio1      = irq_power_pkg::RESET_BYTE;
      next_state.prio2      = irq_power_pkg::RESET_BYTE;
      next_state.gie        = 1'b0;
      next_state.svc_low    = 1'b0;
      next_state.svc_high   = 1'b0;
      next_state.disp_req   = 1'b0;
      next_state.disp_high  = 1'b0;
      next_state.disp_vec   = 4'h0;
      next_state.core_reset = 1'b1;
    end

    // sticky status, set wins over write-one clear
    if (apb_write && paddr_in == irq_power_pkg::ADDR_STATUS)
    begin
      next_state.status = state.status & ~wbyte;
    end
    next_state.status = (next_state.status | status_set) & irq_power_pkg::STATUS_BITS;

    next_state.cpu_halt   = next_state.mode != irq_power_pkg::MODE_RUN;
    next_state.clock_stop = next_state.mode == irq_power_pkg::MODE_STOP;
    next_state.irq        = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state      <= '0;
      state.mode <= irq_power_pkg::MODE_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign prdata_out        = state.prdata;
  assign pready_out        = state.pready;
  assign pslverr_out       = state.pslverr;
  assign cpu_halt_out      = state.cpu_halt;
  assign clock_stop_out    = state.clock_stop;
  assign core_reset_out    = state.core_reset;
  assign dispatch_req_out  = state.disp_req;
  assign dispatch_vec_out  = state.disp_vec;
  assign dispatch_high_out = state.disp_high;
  assign irq_out           = state.irq;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence idle_entry_seq;
    state.mode == irq_power_pkg::MODE_RUN && state.idle_arm && !state.stop_arm
      && instr_done_in && !reset_event;
  endsequence

  sequence idle_wake_seq;
    state.mode == irq_power_pkg::MODE_IDLE && (|qual) && !reset_event;
  endsequence

  enable_unused_a: assert property (state.enable2[7] == 1'b0 && state.enable2[5] == 1'b0)
    else $error("unused enable bits set");
  prio_unused_a: assert property (state.prio2[7] == 1'b0 && state.prio2[5] == 1'b0)
    else $error("unused priority bits set");
  power_reads_zero_a: assert property ((apb_setup && paddr_in == irq_power_pkg::ADDR_POWER)
    |=> pready_out && prdata_out == 32'h00000000)
    else $error("power control read not zero");
  idle_entry_a: assert property (idle_entry_seq |=> cpu_halt_out && !clock_stop_out)
    else $error("idle not entered");
  idle_wake_a: assert property (idle_wake_seq |=> !cpu_halt_out)
    else $error("idle not left on interrupt");
  stop_holds_a: assert property ((state.mode == irq_power_pkg::MODE_STOP && !reset_event)
    |=> clock_stop_out && cpu_halt_out)
    else $error("stop left without reset");
  reset_exit_a: assert property (reset_event |=> core_reset_out && !cpu_halt_out
    && !clock_stop_out ##1 (core_reset_out == $past(reset_event)))
    else $error("reset did not end power mode");
  high_no_preempt_a: assert property ((state.svc_high && !reset_event) |=> !dispatch_req_out)
    else $error("high service preempted");
  gie_block_a: assert property (!state.gie |=> !dispatch_req_out && (core_reset_out
    || state.mode != irq_power_pkg::MODE_RUN || $past(state.mode) == irq_power_pkg::MODE_RUN))
    else $error("request forwarded with global enable off");
  halt_regs_a: assert property ((state.mode != irq_power_pkg::MODE_RUN && !reset_event)
    |=> $stable(state.enable2) && $stable(state.prio1) && $stable(state.prio2))
    else $error("register changed while halted");

endmodule
`default_nettype wire

// ==== core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // from the controller
  input  wire logic cpu_halt_in,
  input  wire logic dispatch_req_in,
  // bench control
  input  wire logic ret_req_in,
  // to the controller
  output logic      instr_done_out,
  output logic      ack_out,
  output logic      return_from_interrupt_out
);
  logic [1:0] phase;

  // an instruction ends every fourth cycle; a halted core ends none and acks nothing
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      phase          <= 2'h0;
      instr_done_out <= 1'b0;
      ack_out        <= 1'b0;
      return_from_interrupt_out       <= 1'b0;
    end
    else
    begin
      phase          <= phase + 2'h1;
      instr_done_out <= !cpu_halt_in && phase == 2'h3;
      ack_out        <= !cpu_halt_in && dispatch_req_in && !ack_out;
      return_from_interrupt_out       <= ret_req_in;
    end
  end
endmodule
`default_nettype wire

// ==== interrupt_mask_priority_power_modes_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module interrupt_mask_priority_power_modes_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        idone;
  logic        ack;
  logic        return_from_interrupt;
  logic        halt;
  logic        cstop;
  logic        creset;
  logic        dreq;
  logic [3:0]  dvec;
  logic        dhigh;
  logic        irq;
  logic [7:0]  fen;
  logic [7:0]  pf;
  logic [7:0]  ps;
  logic [3:0]  kick;
  logic [31:0] rv;
  logic        er;
  logic [7:0]  v;
  int          error_cnt;
  int          compares;
  int          cycles;
  int          seed;
  logic [11:0] addrs [7] = '{irq_power_pkg::ADDR_POWER, irq_power_pkg::ADDR_ENABLE2,
    irq_power_pkg::ADDR_PRIO1, irq_power_pkg::ADDR_PRIO2, irq_power_pkg::ADDR_CONTROL,
    irq_power_pkg::ADDR_STATUS, irq_power_pkg::ADDR_MASK};

  irq_power_ctrl dut (
    .ref_clk_in             (clk),
    .sys_rst_in             (rst),
    .psel_in                (psel),
    .penable_in             (pen),
    .pwrite_in              (pwr),
    .paddr_in               (paddr),
    .pwdata_in              (pwdata),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .instr_done_in          (idone),
    .ack_in                 (ack),
    .return_from_interrupt_in                (return_from_interrupt),
    .first_enable_in        (fen),
    .cpu_halt_out           (halt),
    .clock_stop_out         (cstop),
    .core_reset_out         (creset),
    .dispatch_req_out       (dreq),
    .dispatch_vec_out       (dvec),
    .dispatch_high_out      (dhigh),
    .pend_first_in          (pf),
    .pend_second_in         (ps),
    .watchdog_reset_in      (kick[1]),
    .missing_clock_reset_in (kick[2]),
    .ext_reset_pin_in       (kick[3]),
    .irq_out                (irq)
  );

  core_model partner (
    .ref_clk_in      (clk),
    .sys_rst_in      (rst),
    .cpu_halt_in     (halt),
    .dispatch_req_in (dreq),
    .ret_req_in      (kick[0]),
    .instr_done_out  (idone),
    .ack_out         (ack),
    .return_from_interrupt_out        (return_from_interrupt)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task finish_test();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // one transfer; idle cycle afterwards so setups never collide
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // no local limit: pready or the bench timeout ends this wait
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rv, {24'h0, exp});
  endtask

  function logic pick(input int s);
    return s == 0 ? halt : s == 1 ? dreq : s == 2 ? cstop : creset;
  endfunction

  task wait_sig(input int s, input logic val);
    int n;
    n = 0;
    while (pick(s) !== val && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(pick(s)), 32'(val));
  endtask

  task pulse(input int idx, input int len);
    kick[idx] <= 1'b1;
    repeat (len) @(posedge clk);
    kick[idx] <= 1'b0;
  endtask

  initial
  begin
    seed = 32'h01dc;
    {psel, pen, pwr, paddr, pwdata} = '0;
    {fen, pf, ps, kick} = '0;
    error_cnt = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    apb(1'b0, 12'h100, 8'h00);
    chk(32'(er), 32'h1);
    repeat (4)
    begin
      v = 8'($random(seed));
      wr(irq_power_pkg::ADDR_ENABLE2, v);
      rd(irq_power_pkg::ADDR_ENABLE2, v & irq_power_pkg::ENABLE2_BITS);
      wr(irq_power_pkg::ADDR_PRIO1, ~v);
      rd(irq_power_pkg::ADDR_PRIO1, ~v);
      wr(irq_power_pkg::ADDR_PRIO2, v);
      rd(irq_power_pkg::ADDR_PRIO2, v & irq_power_pkg::PRIO2_BITS);
    end
    // masked bit 0 and enabled bit 4 pending, global enable off
    wr(irq_power_pkg::ADDR_PRIO1, 8'h00);
    wr(irq_power_pkg::ADDR_PRIO2, 8'h00);
    wr(irq_power_pkg::ADDR_ENABLE2, 8'h10);
    wr(irq_power_pkg::ADDR_CONTROL, 8'h00);
    ps <= 8'h11;
    repeat (8) @(posedge clk);
    chk(32'(dreq), 32'h0);
    wr(irq_power_pkg::ADDR_CONTROL, 8'h01);
    wait_sig(1, 1'b1);
    chk(32'(dvec), 32'hC);
    repeat (4) @(posedge clk);
    chk(32'(dreq), 32'h0);
    wr(irq_power_pkg::ADDR_PRIO1, 8'h20);
    fen <= 8'h20;
    pf <= 8'h20;
    wait_sig(1, 1'b1);
    chk({dhigh, dvec}, 32'h15);
    pf <= 8'h00;
    pulse(0, 1);
    repeat (4) @(posedge clk);
    chk(32'(dreq), 32'h0);
    pulse(0, 1);
    wait_sig(1, 1'b1);
    ps <= 8'h00;
    pulse(1, 1);
    wait_sig(3, 1'b1);
    rd(irq_power_pkg::ADDR_ENABLE2, 8'h00);
    // idle entry, frozen registers, wake by enabled request
    wr(irq_power_pkg::ADDR_CONTROL, 8'h01);
    wr(irq_power_pkg::ADDR_MASK, 8'h01);
    wr(irq_power_pkg::ADDR_ENABLE2, 8'h01);
    wr(irq_power_pkg::ADDR_POWER, 8'h01);
    wait_sig(0, 1'b1);
    rd(irq_power_pkg::ADDR_POWER, 8'h00);
    rd(irq_power_pkg::ADDR_STATUS, 8'h01);
    chk(32'(irq), 32'h1);
    wr(irq_power_pkg::ADDR_PRIO1, 8'hFF);
    rd(irq_power_pkg::ADDR_PRIO1, 8'h00);
    ps <= 8'h01;
    wait_sig(0, 1'b0);
    wait_sig(1, 1'b1);
    chk(32'(dvec), 32'h8);
    ps <= 8'h00;
    rd(irq_power_pkg::ADDR_STATUS, 8'h03);
    wr(irq_power_pkg::ADDR_STATUS, 8'h0F);
    rd(irq_power_pkg::ADDR_STATUS, 8'h00);
    chk(32'(irq), 32'h0);
    // both bits armed: stop wins, interrupts cannot end it
    wr(irq_power_pkg::ADDR_POWER, 8'h03);
    wait_sig(2, 1'b1);
    ps <= 8'h01;
    repeat (20) @(posedge clk);
    chk(32'(halt), 32'h1);
    pulse(2, 1);
    wait_sig(3, 1'b1);
    wait_sig(0, 1'b0);
    chk(32'(cstop), 32'h0);
    ps <= 8'h00;
    rd(irq_power_pkg::ADDR_STATUS, 8'h0C);
    // external pin ends idle
    wr(irq_power_pkg::ADDR_POWER, 8'h01);
    wait_sig(0, 1'b1);
    pulse(3, 3);
    wait_sig(3, 1'b1);
    wait_sig(0, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
